// ---- logic/spi_host_pkg.sv ----
`default_nettype none
package spi_host_pkg;
  localparam int          CLK_HZ         = 10_000_000;
  localparam int          GAP_NS         = 50_000;
  localparam int          GAP_CYC        = (GAP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int          SCK_HALF_CYC   = 4;
  localparam logic [7:0]  CMD_READ_REG   = 8'h01;
  localparam logic [7:0]  CMD_WRITE_REG  = 8'h02;
  localparam logic [7:0]  CMD_WRITE_NV   = 8'h03;
  localparam logic [7:0]  CMD_RESTORE    = 8'h04;
  localparam logic [7:0]  CMD_RESET      = 8'h06;
  localparam logic [15:0] CRC_INIT       = 16'h0000;
  localparam logic [7:0]  XOR_INIT       = 8'h00;
  localparam logic [1:0]  CHK_XOR        = 2'h0;
  localparam logic [1:0]  CHK_CRC        = 2'h1;
  localparam logic [1:0]  CHK_OFF        = 2'h2;
  localparam int          HDR_ERR_BYTE   = 3;
  localparam int          HDR_ECHO_BYTE  = 1;
endpackage
`default_nettype wire

// ---- logic/spi_cmd_host.sv ----
// Summary of operation
// - Checksum is XOR of bytes between start character and asterisk.
// - Stronger option uses a 16-bit CCITT CRC instead of XOR.
// - CRC starts at zero; swap, xor byte, shift-xor steps per byte.
// - CRC goes into the message as four hex characters.
// - Select driven low starts each command transaction.
// - Select and clock are both active low.
// - First byte is command id; length depends on command.
// - Bytes MSB first; multibyte values little-endian.
// - Pad bytes align 16-bit and 32-bit fields.
// - To collect a response, clock enough bytes while sending zeros.
// - At least 50 us between transactions.
// - Read request: code, register id, zero fill bytes.
// - Command ids: 01 read, 02 write, 03 save, 04 restore, 06 reset.
// - Text frame: start, name, comma, params, asterisk, check, newline.
`timescale 1ns/1ns
`default_nettype none
module spi_cmd_host #(
  parameter int MAX_BYTES = 16,
  parameter int GAP_CYCLES = spi_host_pkg::GAP_CYC
) (
  input  wire logic                      core_clk,     // System clock
  input  wire logic                      rst_n,        // Async reset, low
  input  wire logic                      start,        // Pulse: begin transaction
  input  wire logic                      abort,        // Pulse: release select early
  input  wire logic [4:0]                nbytes,       // Bytes to clock, 1..MAX_BYTES
  input  wire logic [8*MAX_BYTES-1:0]    tx_bytes,     // Byte i at [8i+:8]
  input  wire logic [1:0]                chk_mode,     // Text check selection
  input  wire logic                      chk_clr,      // Pulse: restart check
  input  wire logic                      chk_valid,    // Pulse: text byte present
  input  wire logic [7:0]                chk_byte,     // Text byte
  input  wire logic                      miso,         // Device data out
  output logic                           ss_n,         // Select, active low
  output logic                           sck_n,        // Clock, idles high
  output logic                           mosi,         // Host data out
  output logic                           busy,         // Transaction or gap running
  output logic                           done,         // Pulse: transfer complete
  output logic [8*MAX_BYTES-1:0]         rx_bytes,     // Received bytes
  output logic [7:0]                     resp_cmd,     // Echoed command byte
  output logic [7:0]                     resp_err,     // Error code byte
  output logic [15:0]                    chk_value     // Running check value
);
  import spi_host_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LOW  = 4'b0010,
    ST_HIGH = 4'b0100,
    ST_GAP  = 4'b1000
  } state_e;

  function automatic logic [15:0] crc_step(input logic [15:0] c_in, input logic [7:0] b);
    logic [15:0] c;
    c = {c_in[7:0], c_in[15:8]};
    c = c ^ {8'h00, b};
    c = c ^ {12'h000, c[7:4]};
    c = c ^ (c << 12);
    c = c ^ {3'h0, c[7:0], 5'h00};
    return c;
  endfunction

  state_e                 st_r;
  state_e                 st_nxt;
  logic                   ss_n_nxt;
  logic                   sck_n_nxt;
  logic                   mosi_nxt;
  logic                   busy_nxt;
  logic                   done_nxt;
  logic [2:0]             div_r;
  logic [2:0]             bit_r;
  logic [2:0]             bit_nxt;
  logic [4:0]             byte_r;
  logic [4:0]             byte_nxt;
  logic [7:0]             sh_r;
  logic [7:0]             sh_nxt;
  logic [15:0]            gap_r;
  logic [15:0]            gap_nxt;
  logic [8*MAX_BYTES-1:0] txb_r;
  logic [8*MAX_BYTES-1:0] txb_nxt;
  logic [4:0]             nb_r;
  logic [4:0]             nb_nxt;
  logic [8*MAX_BYTES-1:0] rx_nxt;
  logic [7:0]             resp_cmd_nxt;
  logic [7:0]             resp_err_nxt;
  logic                   miso_m_r;
  logic                   miso_s_r;

  wire tick      = (div_r == 3'(SCK_HALF_CYC - 1));
  wire last_bit  = (bit_r == 3'h0);
  wire last_byte = (byte_r == nb_r - 5'h01);
  wire [7:0] cur_tx  = txb_r[8*byte_r +: 8];
  wire [7:0] rx_full = {sh_r[6:0], miso_s_r};
  wire [15:0] crc_nxt = crc_step(chk_value, chk_byte);
  wire [4:0] nb_clip = (nbytes == 5'h00) ? 5'h01 :
                       (nbytes > 5'(MAX_BYTES)) ? 5'(MAX_BYTES) : nbytes;
  wire [2:0] bit_dec    = bit_r - 3'h1;
  wire [4:0] byte_inc   = byte_r + 5'h01;
  wire       in_frame   = (st_r == ST_LOW) || (st_r == ST_HIGH);
  wire       bad_state  = !in_frame && (st_r != ST_IDLE) && (st_r != ST_GAP);
  wire       take_start = (st_r == ST_IDLE) && start;
  wire       cut_frame  = in_frame && abort;
  wire       fall_now   = (st_r == ST_LOW) && tick && !abort;
  wire       rise_now   = (st_r == ST_HIGH) && tick && !abort;
  wire       byte_end   = rise_now && last_bit;
  wire       frame_end  = byte_end && last_byte;
  wire       next_byte  = byte_end && !last_byte;
  wire       gap_over   = (st_r == ST_GAP) && (gap_r <= 16'h0001);
  wire       gap_load   = cut_frame || frame_end;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      miso_m_r <= 1'b0;
      miso_s_r <= 1'b0;
    end else begin
      miso_m_r <= miso;
      miso_s_r <= miso_m_r;
    end
  end

  // Clock divider runs only inside a frame so edges stay aligned to select
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      div_r <= 3'h0;
    else if (st_r == ST_LOW || st_r == ST_HIGH)
      div_r <= tick ? 3'h0 : div_r + 3'h1;
    else
      div_r <= 3'h0;
  end

  // Abort wins over the clock divider in either clock phase
  always_comb begin
    case (st_r)
      ST_IDLE: st_nxt = start ? ST_LOW : ST_IDLE;
      ST_LOW:  st_nxt = abort ? ST_GAP : (tick ? ST_HIGH : ST_LOW);
      ST_HIGH: st_nxt = abort ? ST_GAP : (!tick ? ST_HIGH : (frame_end ? ST_GAP : ST_LOW));
      ST_GAP:  st_nxt = gap_over ? ST_IDLE : ST_GAP;
      default: st_nxt = ST_IDLE;
    endcase
  end

  // Select falls on start, rises on completion or abort
  assign ss_n_nxt  = take_start ? 1'b0 :
                     (gap_load || bad_state) ? 1'b1 : ss_n;
  // Sampling on the rising (trailing) edge of the active-low clock
  assign sck_n_nxt = cut_frame ? 1'b1 :
                     fall_now ? 1'b0 :
                     rise_now ? 1'b1 : sck_n;
  assign mosi_nxt  = take_start ? tx_bytes[7] :
                     (rise_now && !last_bit) ? cur_tx[bit_dec] :
                     next_byte ? txb_r[8*byte_inc + 7] :
                     (st_r == ST_GAP) ? 1'b0 : mosi;
  assign busy_nxt  = take_start ? 1'b1 :
                     (gap_over || bad_state) ? 1'b0 : busy;
  assign done_nxt  = frame_end;
  assign bit_nxt   = (take_start || next_byte) ? 3'h7 :
                     (rise_now && !last_bit) ? bit_dec : bit_r;
  assign byte_nxt  = take_start ? 5'h00 :
                     next_byte ? byte_inc : byte_r;
  assign sh_nxt    = rise_now ? rx_full : sh_r;
  assign gap_nxt   = gap_load ? 16'(GAP_CYCLES) :
                     ((st_r == ST_GAP) && !gap_over) ? gap_r - 16'h0001 : gap_r;
  assign txb_nxt   = take_start ? tx_bytes : txb_r;
  assign nb_nxt    = take_start ? nb_clip : nb_r;
  assign resp_cmd_nxt = (byte_end && byte_r == 5'(HDR_ECHO_BYTE)) ? rx_full : resp_cmd;
  assign resp_err_nxt = (byte_end && byte_r == 5'(HDR_ERR_BYTE)) ? rx_full : resp_err;

  // Only whole bytes land; a cut frame leaves earlier bytes in place
  always_comb begin
    rx_nxt = rx_bytes;
    if (byte_end)
      rx_nxt[8*byte_r +: 8] = rx_full;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      st_r <= ST_IDLE;
    else
      st_r <= st_nxt;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      ss_n <= 1'b1;
    else
      ss_n <= ss_n_nxt;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      sck_n <= 1'b1;
    else
      sck_n <= sck_n_nxt;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      mosi <= 1'b0;
    else
      mosi <= mosi_nxt;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      busy <= 1'b0;
    else
      busy <= busy_nxt;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      done <= 1'b0;
    else
      done <= done_nxt;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      bit_r <= 3'h7;
    else
      bit_r <= bit_nxt;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      byte_r <= 5'h00;
    else
      byte_r <= byte_nxt;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      sh_r <= 8'h00;
    else
      sh_r <= sh_nxt;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      gap_r <= 16'h0000;
    else
      gap_r <= gap_nxt;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      txb_r <= '0;
    else
      txb_r <= txb_nxt;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      nb_r <= 5'h01;
    else
      nb_r <= nb_nxt;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      rx_bytes <= '0;
    else
      rx_bytes <= rx_nxt;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      resp_cmd <= 8'h00;
    else
      resp_cmd <= resp_cmd_nxt;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      resp_err <= 8'h00;
    else
      resp_err <= resp_err_nxt;
  end

  // Text-link integrity engine; caller feeds bytes between start char and asterisk
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      chk_value <= CRC_INIT;
    else if (chk_clr)
      chk_value <= (chk_mode == CHK_CRC) ? CRC_INIT : {8'h00, XOR_INIT};
    else if (chk_valid) begin
      case (chk_mode)
        CHK_XOR: chk_value <= {8'h00, chk_value[7:0] ^ chk_byte};
        CHK_CRC: chk_value <= crc_nxt;
        default: chk_value <= 16'h0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- dv/spi_dev_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module spi_dev_model (
  input  wire logic ss_n,  // Select, active low
  input  wire logic sck_n, // Link clock, active low
  input  wire logic mosi,  // Command bits
  output logic      miso   // Response bits
);
  logic [7:0] pend[16] = '{default: 8'h00};
  logic [7:0] cur[16];
  logic [7:0] got[16];
  logic       err;
  int         bits = 0;
  int         upd = 0;
  initial miso = 1'b0;
  always @(negedge ss_n) begin
    bits = 0;
    cur = pend;
  end
  always @(negedge sck_n) if (!ss_n && bits < 128) begin
    got[bits/8][7-bits%8] = mosi;
    miso = cur[bits/8][7-bits%8];
    bits++;
  end
  always @(posedge ss_n) begin
    miso = ~miso; // No pull on this line, so show junk
    if (bits > 0 && bits % 8 == 0) begin // Frames cut mid-byte keep the old answer
      err = got[1] > 8'h30;
      pend = '{default: 8'h00};
      pend[1] = got[0];
      pend[2] = got[1];
      pend[3] = {7'h0, err};
      for (int i = 4; i < 16; i++) pend[i] = err ? 8'h00 : got[1] + upd[7:0] + i[7:0];
      upd++;
    end
  end
endmodule
`default_nettype wire

// ---- dv/spi_cmd_host_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module spi_cmd_host_chk
  import spi_host_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic rst_n,    // Reset, active low
  input wire logic start,    // Request
  input wire logic abort,    // Cancel
  input wire logic ss_n,     // Select
  input wire logic sck_n,    // Link clock
  input wire logic mosi,     // Host data
  input wire logic busy,     // Busy
  input wire logic done      // Done
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence low_phase;
    !sck_n [*4] ##1 sck_n;
  endsequence
  a_idle_clk_high: assert property (ss_n |-> sck_n)
    else $error("clock active while deselected");
  a_start_selects: assert property (start && !busy |=> !ss_n && busy)
    else $error("start did not select");
  a_clk_phase: assert property ($fell(sck_n) |-> low_phase)
    else $error("clock low phase wrong");
  a_mosi_steady: assert property (!sck_n && $past(!sck_n) |-> $stable(mosi))
    else $error("mosi moved in low phase");
  a_done_at_end: assert property (done |-> ss_n && $past(!ss_n))
    else $error("done without frame end");
  a_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_abort_release: assert property (abort && !ss_n |-> ##[1:4] ss_n)
    else $error("abort kept select low");
  a_gap_kept: assert property ($rose(ss_n) |-> ss_n [*8])
    else $error("gap too short");
  a_frame_busy: assert property (!ss_n |-> busy)
    else $error("frame without busy");
  // Cycles with select high since the last frame, saturating
  logic [15:0] hi_cnt_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      hi_cnt_r <= 16'hFFFF;
    else if (!ss_n)
      hi_cnt_r <= 16'h0000;
    else if (hi_cnt_r != 16'hFFFF)
      hi_cnt_r <= hi_cnt_r + 16'h0001;
  end
  a_gap_min: assert property ($fell(ss_n) |-> hi_cnt_r >= 16'(GAP_CYC))
    else $error("select gap under minimum");
endmodule
bind spi_cmd_host spi_cmd_host_chk i_chk (.core_clk(core_clk), .rst_n(rst_n), .start(start), .abort(abort),
  .ss_n(ss_n), .sck_n(sck_n), .mosi(mosi), .busy(busy), .done(done));
`default_nettype wire

// ---- dv/sensor_spi_command_link_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module sensor_spi_command_link_tb_top;
  import spi_host_pkg::*;
  logic         core_clk = 0, rst_n = 0, start = 0, abort = 0, chk_clr = 0, chk_valid = 0;
  logic         miso, ss_n, sck_n, mosi, busy, done;
  logic [4:0]   nbytes = '0;
  logic [127:0] tx_bytes = '0, rx_bytes;
  logic [1:0]   chk_mode = '0;
  logic [7:0]   chk_byte = '0, resp_cmd, resp_err, b;
  logic [15:0]  chk_value, crc;
  logic [7:0]   exp_q[16] = '{default: 8'h00};
  logic [7:0]   cmds[5] = '{CMD_WRITE_REG, CMD_WRITE_NV, CMD_RESTORE, CMD_RESET, CMD_READ_REG};
  logic [31:0]  seed = 32'h4425CDDF;
  int           fails = 0, check_count = 0, upd = 0, cyc = 0, dn = 0;
  spi_cmd_host #(.MAX_BYTES(16), .GAP_CYCLES(GAP_CYC)) i_spi_cmd_host (.core_clk(core_clk), .rst_n(rst_n),
    .start(start), .abort(abort), .nbytes(nbytes), .tx_bytes(tx_bytes), .chk_mode(chk_mode), .chk_clr(chk_clr),
    .chk_valid(chk_valid), .chk_byte(chk_byte), .miso(miso), .ss_n(ss_n), .sck_n(sck_n), .mosi(mosi),
    .busy(busy), .done(done), .rx_bytes(rx_bytes), .resp_cmd(resp_cmd), .resp_err(resp_err), .chk_value(chk_value));
  spi_dev_model i_spi_dev_model (.ss_n(ss_n), .sck_n(sck_n), .mosi(mosi), .miso(miso));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] d);
    c = {c[7:0], c[15:8]};
    c ^= {8'h00, d};
    c ^= {12'h000, c[7:4]};
    c ^= c << 12;
    c ^= {3'h0, c[7:0], 5'h00};
    return c;
  endfunction
  task automatic chk(string what, logic [15:0] e, logic [15:0] s);
    check_count++;
    if (e !== s) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic summarize();
    $display("fails=%0d check_count=%0d", fails, check_count);
    if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic xfer(logic [7:0] c, logic [7:0] r, logic [4:0] n, logic ab);
    logic e;
    tx_bytes <= {112'h0, r, c};
    nbytes <= n;
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    repeat (ab ? 20 : 0) @(posedge core_clk);
    abort <= ab;
    @(posedge core_clk);
    abort <= 1'b0;
    do @(negedge core_clk); while (busy === 1'b1);
    if (!ab) begin
      for (int i = 0; i < n; i++) chk("rx byte", exp_q[i], rx_bytes[8*i+:8]);
      chk("echo", exp_q[1], resp_cmd);
      chk("error", exp_q[3], resp_err);
      chk("done pulses", 16'(upd + 1), 16'(dn));
      e = r > 8'h30;
      exp_q = '{default: 8'h00};
      exp_q[1] = c;
      exp_q[2] = r;
      exp_q[3] = {7'h0, e};
      for (int i = 4; i < 16; i++) exp_q[i] = e ? 8'h00 : r + upd[7:0] + i[7:0];
      upd++;
    end
    @(posedge core_clk);
  endtask
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (done === 1'b1) dn <= dn + 1;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    xfer(8'h01, 8'h08, 5'd8, 1'b0);
    xfer(8'h01, 8'h08, 5'd16, 1'b0);
    xfer(8'h01, 8'h08, 5'd16, 1'b0);
    xfer(8'h02, 8'h41, 5'd16, 1'b1);
    xfer(8'h00, 8'h00, 5'd16, 1'b0);
    foreach (cmds[k]) xfer(cmds[k], 8'(xs()) & 8'h3F, 5'd8, 1'b0);
    xfer(8'h01, 8'h41, 5'd16, 1'b0);
    xfer(8'h00, 8'h00, 5'd16, 1'b0);
    for (int m = 0; m < 4; m++) begin
      chk_mode <= m[1:0];
      chk_clr <= 1'b1;
      crc = 16'h0000;
      @(posedge core_clk);
      chk_clr <= 1'b0;
      repeat (6) begin
        b = 8'(xs());
        crc = m == 1 ? crc_step(crc, b) : m == 0 ? crc ^ {8'h00, b} : 16'h0000;
        chk_valid <= 1'b1;
        chk_byte <= b;
        @(posedge core_clk);
      end
      chk_valid <= 1'b0;
      repeat (2) @(negedge core_clk);
      chk("check value", crc, chk_value);
      @(posedge core_clk);
    end
    summarize();
  end
endmodule
`default_nettype wire
